// >>> rtl/scrw_pkg.sv
package scrw_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_CARRIER  = 8'h04;
    localparam logic [7:0] ADDR_CH_BASE  = 8'h08;
    localparam logic [7:0] CH_STRIDE     = 8'h10;
    localparam logic [7:0] OFS_GAIN      = 8'h00;
    localparam logic [7:0] OFS_BIAS      = 8'h04;
    localparam logic [7:0] OFS_TARGET    = 8'h08;
    localparam logic [7:0] OFS_RATE      = 8'h0C;
    localparam logic [7:0] ADDR_APPLIED  = 8'h28;
    localparam logic [7:0] ADDR_SAMPLES  = 8'h2C;

    // control field positions
    localparam int         CTRL_RESOLVER_BIT = 0;
    localparam int         CTRL_GLOBAL_BIT   = 1;
    localparam int         CTRL_POLE_LSB     = 8;
    localparam int         CTRL_POLE_MSB     = 14;

    // reset values and limits
    localparam logic [6:0]  POLE_PAIRS_MAX    = 7'h40;
    localparam logic [6:0]  POLE_PAIRS_RESET  = 7'h01;
    localparam logic [15:0] CARRIER_RESET     = 16'h0042;
    localparam logic [15:0] GAIN_RESET        = 16'h0000;
    localparam logic [15:0] SAMPLE_POS_LIMIT  = 16'h7FFF;
    localparam logic [15:0] SAMPLE_NEG_LIMIT  = 16'h8000;
    localparam logic [15:0] QUARTER_TURN      = 16'h4000;

    // slew timing: one phase step every tick
    localparam int          CLK_PERIOD_NS     = 100;
    localparam int          SLEW_TICK_NS      = 100000;
    localparam int          SLEW_TICK_CYCLES  = (SLEW_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0]  SLEW_TICK_LAST    = 10'(SLEW_TICK_CYCLES - 1);
    // full rate code = 1000 deg/s = 0.1 deg per tick, in 2^-16 angle units, scaled by 2^10
    localparam logic [15:0] SLEW_MUL          = 16'h48D1;
    localparam int          SLEW_SHIFT        = 10;

    // quarter sine, 17 points, Q15
    localparam logic [16:0][15:0] SINE_TABLE = {
        16'h7FFF, 16'h7F61, 16'h7D89, 16'h7A7C, 16'h7641, 16'h70E2,
        16'h6A6D, 16'h62F1, 16'h5A82, 16'h5133, 16'h471C, 16'h3C56,
        16'h30FB, 16'h2528, 16'h18F9, 16'h0C8C, 16'h0000};

    typedef struct packed {
        logic              wrPend;
        logic [7:0]        addr;
        logic [31:0]       rdata;
        logic              ctrlResolver;
        logic              ctrlGlobal;
        logic [6:0]        polePairs;
        logic [15:0]       carrierStep;
        logic [15:0]       carrierPhase;
        logic [9:0]        tickCnt;
        logic [1:0][15:0]  gain;
        logic [1:0][15:0]  bias;
        logic [1:0][15:0]  target;
        logic [1:0][15:0]  rate;
        logic [1:0][31:0]  applied;
        logic [1:0][15:0]  sample;
    } scrw_state_type;
endpackage : scrw_pkg

// >>> rtl/scrw_core.sv
// How it works
// - gain scales waveform, zero to one
// - signed bias per channel, minus one..one
// - encoder output is scaled wave plus bias
// - sum saturates at the normalised window
// - outputs are normalised samples only
// - signed phase target, plus/minus 180 degrees
// - slew rate code, 0 to 1000 deg/s
// - applied phase walks toward target
// - rate zero jumps straight to target
// - sine and cosine a quarter apart
// - resolver multiplies carrier by both envelopes
// - resolver always uses both generators
// - pole pairs limited to 64
// - frequency multiplied by pole pairs
// - phase follows supplied mechanical angle
// - direct setting uses local shift only
// - shifted setting adds global shift
// - global shift moves both channels together
module scrw_core (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_b,
    // ahb-lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic       [31:0] hrdata,
    output logic              hreadyout,
    output logic              hresp,
    // angle from speed generator, same clock
    input  wire logic [15:0]  mechanicalAngleIn,
    input  wire logic [15:0]  globalPhaseOffset,
    // normalised samples to output multiplexer
    output logic       [15:0] sineSample,
    output logic       [15:0] cosineSample
);
    scrw_pkg::scrw_state_type s, n;

    logic [15:0]        mechTotal;
    logic [22:0]        elecProd;
    logic [15:0]        carrier;
    logic               slewTick;
    logic               addrPhase;
    logic [31:0]        rdMux;
    logic [1:0][15:0]   elecPhase;
    logic [1:0][16:0]   biasSum;
    logic [1:0][31:0]   slewStep;

    function automatic logic [7:0] chAddr(input int ch, input logic [7:0] ofs);
        chAddr = 8'(scrw_pkg::ADDR_CH_BASE + 8'(ch) * scrw_pkg::CH_STRIDE + ofs);
    endfunction : chAddr

    // table sine, linear interpolation between points
    // mirrored index tops out one code under the peak
    function automatic logic [15:0] sineLookup(input logic [15:0] ang);
        logic [13:0] u;
        logic [15:0] lo;
        logic [15:0] hi;
        logic [25:0] span;
        logic [15:0] mag;
        u    = ang[14] ? ~ang[13:0] : ang[13:0];
        lo   = scrw_pkg::SINE_TABLE[5'(u[13:10])];
        hi   = scrw_pkg::SINE_TABLE[5'(u[13:10]) + 5'd1];
        span = 26'(hi - lo) * 26'(u[9:0]);
        mag  = lo + span[25:10];
        sineLookup = ang[15] ? 16'(-mag) : mag;
    endfunction : sineLookup

    assign addrPhase = hsel && htrans[1] && hready;
    assign slewTick  = (s.tickCnt == scrw_pkg::SLEW_TICK_LAST);
    assign carrier   = sineLookup(s.carrierPhase);

    // zero wait states, always okay
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = s.rdata;
    assign sineSample   = s.sample[0];
    assign cosineSample = s.sample[1];

    assign mechTotal = s.ctrlGlobal ? 16'(mechanicalAngleIn + globalPhaseOffset)
                                    : mechanicalAngleIn;
    assign elecProd = 23'(mechTotal) * 23'(s.polePairs);

    always_comb begin
        rdMux = 32'h0000_0000;
        if (haddr[31:8] == 24'h00_0000) begin
            if (haddr[7:0] == scrw_pkg::ADDR_CTRL) begin
                rdMux[scrw_pkg::CTRL_RESOLVER_BIT]                    = s.ctrlResolver;
                rdMux[scrw_pkg::CTRL_GLOBAL_BIT]                      = s.ctrlGlobal;
                rdMux[scrw_pkg::CTRL_POLE_MSB:scrw_pkg::CTRL_POLE_LSB] = s.polePairs;
            end
            if (haddr[7:0] == scrw_pkg::ADDR_CARRIER) begin
                rdMux[15:0] = s.carrierStep;
            end
            if (haddr[7:0] == scrw_pkg::ADDR_APPLIED) begin
                rdMux = {s.applied[1][31:16], s.applied[0][31:16]};
            end
            if (haddr[7:0] == scrw_pkg::ADDR_SAMPLES) begin
                rdMux = {s.sample[1], s.sample[0]};
            end
            for (int ch = 0; ch < 2; ch++) begin
                if (haddr[7:0] == chAddr(ch, scrw_pkg::OFS_GAIN)) begin
                    rdMux[15:0] = s.gain[ch];
                end
                if (haddr[7:0] == chAddr(ch, scrw_pkg::OFS_BIAS)) begin
                    rdMux[15:0] = s.bias[ch];
                end
                if (haddr[7:0] == chAddr(ch, scrw_pkg::OFS_TARGET)) begin
                    rdMux[15:0] = s.target[ch];
                end
                if (haddr[7:0] == chAddr(ch, scrw_pkg::OFS_RATE)) begin
                    rdMux[15:0] = s.rate[ch];
                end
            end
        end
    end

    always_comb begin
        logic [6:0]         pp;
        logic [31:0]        fineTarget;
        logic [31:0]        diff;
        logic [31:0]        absDiff;
        logic signed [15:0] wave;
        logic signed [32:0] scaled33;
        logic signed [15:0] scaled;
        logic signed [31:0] modProd;
        pp         = 7'h00;
        fineTarget = 32'h0000_0000;
        diff       = 32'h0000_0000;
        absDiff    = 32'h0000_0000;
        wave       = 16'sh0000;
        scaled33   = 33'sh0_0000_0000;
        scaled     = 16'sh0000;
        modProd    = 32'sh0000_0000;
        n          = s;
        elecPhase  = '0;
        biasSum    = '0;
        slewStep   = '0;

        // register writes land in the data phase
        n.wrPend = 1'b0;
        if (s.wrPend) begin
            if (s.addr == scrw_pkg::ADDR_CTRL) begin
                n.ctrlResolver = hwdata[scrw_pkg::CTRL_RESOLVER_BIT];
                n.ctrlGlobal   = hwdata[scrw_pkg::CTRL_GLOBAL_BIT];
                pp = hwdata[scrw_pkg::CTRL_POLE_MSB:scrw_pkg::CTRL_POLE_LSB];
                if (pp > scrw_pkg::POLE_PAIRS_MAX) begin
                    pp = scrw_pkg::POLE_PAIRS_MAX;
                end
                if (pp == 7'h00) begin
                    pp = scrw_pkg::POLE_PAIRS_RESET;
                end
                n.polePairs = pp;
            end
            if (s.addr == scrw_pkg::ADDR_CARRIER) begin
                n.carrierStep = hwdata[15:0];
            end
            for (int ch = 0; ch < 2; ch++) begin
                if (s.addr == chAddr(ch, scrw_pkg::OFS_GAIN)) begin
                    n.gain[ch] = hwdata[15:0];
                end
                if (s.addr == chAddr(ch, scrw_pkg::OFS_BIAS)) begin
                    n.bias[ch] = hwdata[15:0];
                end
                if (s.addr == chAddr(ch, scrw_pkg::OFS_TARGET)) begin
                    n.target[ch] = hwdata[15:0];
                end
                if (s.addr == chAddr(ch, scrw_pkg::OFS_RATE)) begin
                    n.rate[ch] = hwdata[15:0];
                end
            end
        end
        if (addrPhase) begin
            n.wrPend = hwrite;
            n.addr   = haddr[31:8] == 24'h00_0000 ? haddr[7:0] : 8'hFF;
            if (!hwrite) begin
                n.rdata = rdMux;
            end
        end

        n.tickCnt      = slewTick ? 10'h000 : 10'(s.tickCnt + 10'h001);
        n.carrierPhase = 16'(s.carrierPhase + s.carrierStep);

        for (int ch = 0; ch < 2; ch++) begin
            fineTarget   = {s.target[ch], 16'h0000};
            diff         = 32'(fineTarget - s.applied[ch]);
            absDiff      = diff[31] ? 32'(-diff) : diff;
            slewStep[ch] = 32'((32'(s.rate[ch]) * 32'(scrw_pkg::SLEW_MUL)) >> scrw_pkg::SLEW_SHIFT);
            if (s.rate[ch] == 16'h0000 || absDiff <= slewStep[ch]) begin
                if (s.rate[ch] == 16'h0000 || slewTick) begin
                    n.applied[ch] = fineTarget;
                end
            end else if (slewTick) begin
                n.applied[ch] = diff[31] ? 32'(s.applied[ch] - slewStep[ch])
                                         : 32'(s.applied[ch] + slewStep[ch]);
            end

            elecPhase[ch] = 16'(elecProd[15:0] + s.applied[ch][31:16]
                                + (ch == 1 ? scrw_pkg::QUARTER_TURN : 16'h0000));
            wave     = $signed(sineLookup(elecPhase[ch]));
            scaled33 = 33'(wave) * $signed({17'h0_0000, s.gain[ch]});
            scaled   = scaled33[31:16];
            biasSum[ch] = 17'($signed(scaled) + $signed(s.bias[ch]));
            if (s.ctrlResolver) begin
                modProd = 32'(scaled) * 32'($signed(carrier));
                n.sample[ch] = modProd[30:15];
            end else if ($signed(biasSum[ch]) > $signed({1'b0, scrw_pkg::SAMPLE_POS_LIMIT})) begin
                n.sample[ch] = scrw_pkg::SAMPLE_POS_LIMIT;
            end else if ($signed(biasSum[ch]) < $signed({1'b1, scrw_pkg::SAMPLE_NEG_LIMIT})) begin
                n.sample[ch] = scrw_pkg::SAMPLE_NEG_LIMIT;
            end else begin
                n.sample[ch] = biasSum[ch][15:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s              <= '0;
            s.polePairs    <= scrw_pkg::POLE_PAIRS_RESET;
            s.carrierStep  <= scrw_pkg::CARRIER_RESET;
            s.gain         <= {2{scrw_pkg::GAIN_RESET}};
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence targetWrite0;
        s.wrPend && s.addr == chAddr(0, scrw_pkg::OFS_TARGET);
    endsequence
    sequence zeroRateHeld0;
        s.rate[0] == 16'h0000 && !s.wrPend;
    endsequence

    AST_POLE_RANGE: assert property (
        s.polePairs >= 7'h01 && s.polePairs <= scrw_pkg::POLE_PAIRS_MAX)
        else $error("pole pair count out of range");

    AST_TARGET_WRITE: assert property (
        targetWrite0 |=> s.target[0] == $past(hwdata[15:0]))
        else $error("phase target write lost");

    AST_ZERO_RATE_JUMP: assert property (
        targetWrite0 ##0 (s.rate[0] == 16'h0000) ##1 zeroRateHeld0
        |=> s.applied[0][31:16] == $past(s.target[0]))
        else $error("zero slew rate did not jump");

    AST_SLEW_HOLD: assert property (
        (s.rate[0] != 16'h0000 && !slewTick) |=> $stable(s.applied[0]))
        else $error("applied phase moved off tick");

    AST_SLEW_STEP: assert property (
        (s.rate[1] != 16'h0000 && slewTick) |=>
        ($past(s.applied[1]) - s.applied[1] <= $past(slewStep[1])) ||
        (s.applied[1] - $past(s.applied[1]) <= $past(slewStep[1])))
        else $error("applied phase jumped past slew step");

    AST_QUARTER_APART: assert property (
        16'(elecPhase[1] - elecPhase[0] - s.applied[1][31:16] + s.applied[0][31:16])
        == scrw_pkg::QUARTER_TURN)
        else $error("channels not a quarter apart");

    AST_SAT_HIGH: assert property (
        (!s.ctrlResolver && $signed(biasSum[1]) > 17'sh0_7FFF)
        |=> cosineSample == scrw_pkg::SAMPLE_POS_LIMIT)
        else $error("cosine sample not saturated high");

    AST_SAT_LOW: assert property (
        (!s.ctrlResolver && $signed(biasSum[1]) < -17'sh0_8000)
        |=> cosineSample == scrw_pkg::SAMPLE_NEG_LIMIT)
        else $error("cosine sample not saturated low");

    AST_IN_WINDOW: assert property (
        (!s.ctrlResolver && $signed(biasSum[0]) <= 17'sh0_7FFF
         && $signed(biasSum[0]) >= -17'sh0_8000)
        |=> sineSample == $past(biasSum[0][15:0]))
        else $error("in-window sine sum altered");

    AST_BIAS_ONLY: assert property (
        (!s.ctrlResolver && s.gain[1] == 16'h0000) |=> cosineSample == $past(s.bias[1]))
        else $error("cosine sample not equal to bias");

    AST_RESOLVER_NULL: assert property (
        (s.ctrlResolver && (carrier == 16'h0000 || s.gain == '0))
        |=> sineSample == 16'h0000 && cosineSample == 16'h0000)
        else $error("resolver output not zero without drive");

    AST_SAMPLE_READ: assert property (
        (addrPhase && !hwrite && haddr == {24'h00_0000, scrw_pkg::ADDR_SAMPLES})
        |=> hrdata == $past({cosineSample, sineSample}))
        else $error("sample word read wrong");

    AST_DIRECT_ANGLE: assert property (
        (!s.ctrlGlobal && $changed(globalPhaseOffset) && $stable(mechanicalAngleIn)
         && $stable(s.polePairs)) |-> $stable(elecProd))
        else $error("direct setting used global shift");

    // tick spacing
    AST_TICK_SPACING: assert property (
        slewTick |=> !slewTick [*8])
        else $error("slew ticks too close");
endmodule : scrw_core

// >>> sim/scrw_out_mux_model.sv
module scrw_out_mux_model #(
    parameter int REF_MV = 10000
) (
    // normalised samples in
    input  wire logic        [15:0] sineSample,
    input  wire logic        [15:0] cosineSample,
    // output levels in millivolts
    output logic signed      [31:0] sineMv,
    output logic signed      [31:0] cosineMv
);
    timeunit 1ns;
    timeprecision 1ns;
    assign sineMv   = (32'(signed'(sineSample)) * REF_MV) >>> 15;
    assign cosineMv = (32'(signed'(cosineSample)) * REF_MV) >>> 15;
endmodule : scrw_out_mux_model

// >>> sim/tb_sine_cosine_resolver_wavegen.sv
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_sine_cosine_resolver_wavegen;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] SIN = scrw_pkg::ADDR_CH_BASE;
    localparam logic [7:0] COS = SIN + scrw_pkg::CH_STRIDE;
    logic               mclk = 1'b0;
    logic               rst_b, hsel, hwrite, hreadyout, hresp;
    logic        [31:0] haddr, hwdata, hrdata, rd;
    logic        [1:0]  htrans;
    logic        [2:0]  hsize;
    logic        [15:0] mechAngle, globalOfs, sineSample, cosineSample;
    logic signed [31:0] sineMv, cosineMv;
    int                 failures = 0;
    int                 comparisons = 0;
    int                 posSeen, negSeen;

    always #50 mclk = ~mclk;

    scrw_core u_dut (
        .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .mechanicalAngleIn(mechAngle), .globalPhaseOffset(globalOfs),
        .sineSample(sineSample), .cosineSample(cosineSample)
    );

    scrw_out_mux_model u_mux (
        .sineSample(sineSample), .cosineSample(cosineSample),
        .sineMv(sineMv), .cosineMv(cosineMv)
    );

    task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b1;
        haddr  <= {24'h00_0000, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
    endtask : busWrite

    task automatic busRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b0;
        haddr  <= {24'h00_0000, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : busRead

    task automatic waitc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : waitc

    task automatic setAngle(input logic [15:0] m, input logic [15:0] g);
        @(posedge mclk);
        mechAngle <= m;
        globalOfs <= g;
        waitc(3);
    endtask : setAngle

    // one channel carries the carrier, the other must stay at zero
    task automatic scan(input bit useCos);
        logic [15:0] live;
        logic [15:0] idle;
        posSeen = 0;
        negSeen = 0;
        repeat (1000) begin
            @(posedge mclk);
            #1;
            live = useCos ? cosineSample : sineSample;
            idle = useCos ? sineSample : cosineSample;
            `CHECK(idle, 16'h0000)
            if ($signed(live) > 16'sh4000) posSeen++;
            if ($signed(live) < -16'sh4000) negSeen++;
        end
        `CHECK(posSeen > 0 && negSeen > 0, 1'b1)
    endtask : scan

    task automatic print_verdict();
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    initial begin
        {rst_b, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {mechAngle, globalOfs} = '0;
        hsize = 3'h2;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        busRead(scrw_pkg::ADDR_CTRL, rd);
        `CHECK(rd, 32'h0000_0100)
        busRead(scrw_pkg::ADDR_SAMPLES, rd);
        `CHECK(rd, 32'h0000_0000)
        // unmapped place ignores writes
        busWrite(8'h80, 32'hFFFF_FFFF);
        busRead(8'h80, rd);
        `CHECK(rd, 32'h0000_0000)
        busWrite(SIN + scrw_pkg::OFS_GAIN, 32'h0000_FFFF);
        busWrite(COS + scrw_pkg::OFS_GAIN, 32'h0000_FFFF);
        waitc(3);
        `CHECK(sineSample, 16'h0000)
        `CHECK(cosineSample, 16'h7FFD)
        busRead(scrw_pkg::ADDR_SAMPLES, rd);
        `CHECK(rd, 32'h7FFD_0000)
        busWrite(SIN + scrw_pkg::OFS_BIAS, 32'h0000_4000);
        busWrite(COS + scrw_pkg::OFS_BIAS, 32'h0000_4000);
        waitc(3);
        `CHECK(sineSample, 16'h4000)
        `CHECK(cosineSample, 16'h7FFF)
        `CHECK(sineMv, 32'h0000_1388)
        busWrite(COS + scrw_pkg::OFS_BIAS, 32'h0000_C000);
        setAngle(16'h8000, 16'h0000);
        `CHECK(sineSample, 16'h4000)
        `CHECK(cosineSample, 16'h8000)
        `CHECK(cosineMv, 32'hFFFF_D8F0)
        busWrite(SIN + scrw_pkg::OFS_BIAS, 32'h0000_0000);
        busWrite(COS + scrw_pkg::OFS_BIAS, 32'h0000_0000);
        busWrite(scrw_pkg::ADDR_CTRL, 32'h0000_0400);
        setAngle(16'h1000, 16'h0000);
        `CHECK(sineSample, 16'h7FFD)
        `CHECK(cosineSample, 16'h0000)
        busWrite(scrw_pkg::ADDR_CTRL, 32'h0000_7F00);
        busRead(scrw_pkg::ADDR_CTRL, rd);
        `CHECK(rd, 32'h0000_4000)
        setAngle(16'h0100, 16'h0000);
        `CHECK(sineSample, 16'h7FFD)
        busWrite(scrw_pkg::ADDR_CTRL, 32'h0000_0000);
        busRead(scrw_pkg::ADDR_CTRL, rd);
        `CHECK(rd, 32'h0000_0100)
        busWrite(scrw_pkg::ADDR_CTRL, 32'h0000_0102);
        setAngle(16'h0000, 16'h4000);
        `CHECK(sineSample, 16'h7FFD)
        `CHECK(cosineSample, 16'h0000)
        busWrite(scrw_pkg::ADDR_CTRL, 32'h0000_0100);
        waitc(3);
        `CHECK(sineSample, 16'h0000)
        `CHECK(cosineSample, 16'h7FFD)
        busWrite(SIN + scrw_pkg::OFS_TARGET, 32'h0000_4000);
        busWrite(COS + scrw_pkg::OFS_TARGET, 32'h0000_C000);
        waitc(3);
        busRead(scrw_pkg::ADDR_APPLIED, rd);
        `CHECK(rd, 32'hC000_4000)
        `CHECK(sineSample, 16'h7FFD)
        `CHECK(cosineSample, 16'h0000)
        // slewed move at full rate, about 18 units per tick
        busWrite(SIN + scrw_pkg::OFS_RATE, 32'h0000_FFFF);
        busWrite(COS + scrw_pkg::OFS_RATE, 32'h0000_FFFF);
        busWrite(SIN + scrw_pkg::OFS_TARGET, 32'h0000_4100);
        busRead(scrw_pkg::ADDR_APPLIED, rd);
        `CHECK(rd[15:0] < 16'h4100, 1'b1)
        waitc(2500);
        busRead(scrw_pkg::ADDR_APPLIED, rd);
        `CHECK(rd[15:0] > 16'h4000 && rd[15:0] < 16'h4100, 1'b1)
        waitc(20000);
        busRead(scrw_pkg::ADDR_APPLIED, rd);
        `CHECK(rd, 32'hC000_4100)
        // resolver, sine bias set to show it is ignored
        busWrite(SIN + scrw_pkg::OFS_RATE, 32'h0000_0000);
        busWrite(SIN + scrw_pkg::OFS_TARGET, 32'h0000_0000);
        busWrite(COS + scrw_pkg::OFS_RATE, 32'h0000_0000);
        busWrite(COS + scrw_pkg::OFS_TARGET, 32'h0000_0000);
        busWrite(SIN + scrw_pkg::OFS_BIAS, 32'h0000_4000);
        busWrite(scrw_pkg::ADDR_CTRL, 32'h0000_0101);
        setAngle(16'h0000, 16'h0000);
        scan(1'b1);
        setAngle(16'h4000, 16'h0000);
        scan(1'b0);
        // no gain leaves nothing, bias still ignored
        busWrite(SIN + scrw_pkg::OFS_GAIN, 32'h0000_0000);
        busWrite(COS + scrw_pkg::OFS_GAIN, 32'h0000_0000);
        waitc(3);
        `CHECK(sineSample, 16'h0000)
        `CHECK(cosineSample, 16'h0000)
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        failures++;
        print_verdict();
    end
endmodule : tb_sine_cosine_resolver_wavegen
